// ===== hw/ffp_consts.vh
// Constants for the fault and pwm/indicator register pair.
// Included by the design files; definitions only.
`ifndef FFP_CONSTS_VH
`define FFP_CONSTS_VH

`define FFP_ADDR_FAULT      8'h08
`define FFP_ADDR_PWM        8'h09
`define FFP_FAULT_RESET     8'h00
`define FFP_PWM_RESET       8'h00
`define FFP_FAULT_RSVD_MASK 8'h06

`define FFP_BIT_UVLO        0
`define FFP_BIT_TXMASK      3
`define FFP_BIT_TIMEOUT     4
`define FFP_BIT_OVERTEMP    5
`define FFP_BIT_SHORT       6
`define FFP_BIT_OVP         7

`define FFP_PWM_DUTY_LSB    0
`define FFP_PWM_DUTY_MSB    1
`define FFP_PWM_FREQ_BIT    2

`define FFP_MODE_SHUTDOWN   2'h0
`define FFP_MODE_INDICATOR  2'h1
`define FFP_MODE_ASSIST     2'h2
`define FFP_MODE_FLASH      2'h3

`define FFP_CURRENT_FIXED_MIN 8'h40

// 31.25 kHz PWM at 250 MHz: period in ns and cycles, 16 slots per period
`define FFP_CLK_PERIOD_NS   4
`define FFP_PWM_PERIOD_NS   32000
`define FFP_PWM_PERIOD_CYC  (`FFP_PWM_PERIOD_NS / `FFP_CLK_PERIOD_NS)
`define FFP_PWM_SLOT_CYC    (`FFP_PWM_PERIOD_CYC / 16)
`define FFP_PWM_SLOT_W      9

`endif

// ===== hw/ffp_fault_pwm_regs.v
// Fault status and PWM/indicator control registers of the flash driver.
// Assumes a byte register port with one-cycle read and write strobes,
// detector event pulses synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "ffp_consts.vh"

// Function
// - Undervoltage current reduction during flash sets fault bit 0, held.
// - Transmit-mask input during flash sets fault bit 3.
// - Flash ended by timeout sets fault bit 4.
// - Overtemperature report sets fault bit 5.
// - Shorted LED on either sink output sets fault bit 6.
// - Boost output overvoltage sets fault bit 7.
// - Flags reset to zero; reading returns them then clears them.
// - Fault bits 1 and 2 reserved, read as zero.
// - Indicator mode PWM at 31.25kHz, duty 1/16 to 4/16 by code.
// - Fixed-frequency enable zero allows pulse skipping in all modes.
// - Enable one, flash/assist, current at least 40h: no pulse skipping.
// - Indicator mode always uses pulse skipping.
// - Mode codes: 00 shutdown, 01 indicator, 10 assist, 11 flash.
module ffp_fault_pwm_regs (
	input  wire       clk_sys,
	input  wire       reset,
	input  wire [7:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire       regWrite,
	input  wire       regRead,
	output reg  [7:0] regRdData,
	input  wire [1:0] modeSetting,
	input  wire [7:0] sinkCurrent,
	input  wire       flashActive,
	input  wire       uvloReduce,
	input  wire       txmaskInput,
	input  wire       flashTimeout,
	input  wire       overtempDetect,
	input  wire       shortDetect,
	input  wire       ovpDetect,
	output reg        sinkPwmOn,
	output reg        pulseSkipOn,
	output reg        fixedFreqOn
);
	// Sized copies of the shared constants
	localparam [7:0]   ADDR_FAULT  = `FFP_ADDR_FAULT;
	localparam [7:0]   ADDR_PWM    = `FFP_ADDR_PWM;
	localparam [7:0]   PWM_RESET   = `FFP_PWM_RESET;
	localparam [7:0]   RSVD_MASK   = `FFP_FAULT_RSVD_MASK;
	localparam [7:0]   FIXED_MIN   = `FFP_CURRENT_FIXED_MIN;
	localparam [1:0]   MODE_SHUT   = `FFP_MODE_SHUTDOWN;
	localparam [1:0]   MODE_IND    = `FFP_MODE_INDICATOR;
	localparam [1:0]   MODE_ASST   = `FFP_MODE_ASSIST;
	localparam [1:0]   MODE_FLSH   = `FFP_MODE_FLASH;
	localparam integer SLOT_CYC    = `FFP_PWM_SLOT_CYC;
	localparam [8:0]   SLOT_LAST   = SLOT_CYC[8:0] - 9'h001;

	// Flag positions in the fault register
	localparam integer BIT_UVLO    = `FFP_BIT_UVLO;
	localparam integer BIT_TXMASK  = `FFP_BIT_TXMASK;
	localparam integer BIT_TIMEOUT = `FFP_BIT_TIMEOUT;
	localparam integer BIT_OVERT   = `FFP_BIT_OVERTEMP;
	localparam integer BIT_SHORT   = `FFP_BIT_SHORT;
	localparam integer BIT_OVP     = `FFP_BIT_OVP;

	// Fault flags and their set events
	wire [7:0] faultFlags;
	wire [7:0] faultView;
	wire       uvloEvent;
	wire       txmaskEvent;
	wire       timeoutEvent;
	wire       overtempEvent;
	wire       shortEvent;
	wire       ovpEvent;

	// Register port decode
	wire       hitFault;
	wire       hitPwm;
	wire       readFault;
	wire       writePwm;
	reg  [7:0] next_regRdData;

	// Control register and indicator PWM timing
	reg  [2:0] pwmCtrl;
	reg  [2:0] next_pwmCtrl;
	wire [1:0] dutyCode;
	wire       freqSwitchOn;
	reg  [3:0] dutySlots;
	reg  [8:0] slotCount;
	reg  [8:0] next_slotCount;
	reg  [3:0] slotIndex;
	reg  [3:0] next_slotIndex;
	wire       slotEnd;

	// Converter policy and sink gate
	wire       currentHigh;
	wire       fixedFreqWanted;
	reg        next_sinkPwmOn;
	reg        next_pulseSkipOn;
	reg        next_fixedFreqOn;

	assign hitFault  = (regAddr == ADDR_FAULT);
	assign hitPwm    = (regAddr == ADDR_PWM);
	assign readFault = regRead && hitFault;
	assign writePwm  = regWrite && hitPwm;

	// Undervoltage and transmit-mask count only while a flash runs
	assign uvloEvent     = uvloReduce && flashActive;
	assign txmaskEvent   = txmaskInput && flashActive;
	assign timeoutEvent  = flashTimeout;
	assign overtempEvent = overtempDetect;
	assign shortEvent    = shortDetect;
	assign ovpEvent      = ovpDetect;

	// Reserved positions have no flag behind them
	assign faultFlags[1] = 1'b0;
	assign faultFlags[2] = 1'b0;

	// Each flag: set wins over the clearing read, so no event is lost
	// Undervoltage current reduction
	ffp_sticky_flag uvloFlag (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.setEvent  (uvloEvent),
		.clearFlag (readFault),
		.flag      (faultFlags[BIT_UVLO])
	);

	// Transmit-mask input during a flash
	ffp_sticky_flag txmaskFlag (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.setEvent  (txmaskEvent),
		.clearFlag (readFault),
		.flag      (faultFlags[BIT_TXMASK])
	);

	// Flash cut short by the timeout
	ffp_sticky_flag timeoutFlag (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.setEvent  (timeoutEvent),
		.clearFlag (readFault),
		.flag      (faultFlags[BIT_TIMEOUT])
	);

	// Junction temperature limit crossed
	ffp_sticky_flag overtempFlag (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.setEvent  (overtempEvent),
		.clearFlag (readFault),
		.flag      (faultFlags[BIT_OVERT])
	);

	// Shorted LED on a sink output
	ffp_sticky_flag shortFlag (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.setEvent  (shortEvent),
		.clearFlag (readFault),
		.flag      (faultFlags[BIT_SHORT])
	);

	// Boost output overvoltage
	ffp_sticky_flag ovpFlag (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.setEvent  (ovpEvent),
		.clearFlag (readFault),
		.flag      (faultFlags[BIT_OVP])
	);

	assign faultView = faultFlags & ~RSVD_MASK;

	// Only the duty code and fixed-frequency enable are stored
	always @* begin
		if (writePwm)
			next_pwmCtrl = regWrData[2:0];
		else
			next_pwmCtrl = pwmCtrl;
	end

	always @(posedge clk_sys) begin
		if (reset)
			pwmCtrl <= PWM_RESET[2:0];
		else
			pwmCtrl <= next_pwmCtrl;
	end

	// Read data: fault returns flags before the clear takes effect
	always @* begin
		next_regRdData = regRdData;
		if (regRead) begin
			case (regAddr)
				ADDR_FAULT:
					next_regRdData = faultView;
				ADDR_PWM:
					next_regRdData = {5'h00, pwmCtrl};
				default:
					next_regRdData = 8'h00;
			endcase
		end
	end

	// Indicator duty: code 0..3 gives 1..4 of 16 slots
	assign dutyCode     = pwmCtrl[`FFP_PWM_DUTY_MSB:`FFP_PWM_DUTY_LSB];
	assign freqSwitchOn = pwmCtrl[`FFP_PWM_FREQ_BIT];

	always @* begin
		case (dutyCode)
			2'h0: dutySlots = 4'h1;
			2'h1: dutySlots = 4'h2;
			2'h2: dutySlots = 4'h3;
			2'h3: dutySlots = 4'h4;
			default: dutySlots = 4'h1;
		endcase
	end

	// 16 equal slots make one 31.25 kHz period
	assign slotEnd = (slotCount == SLOT_LAST);

	always @* begin
		if (slotEnd) begin
			next_slotCount = 9'h000;
			next_slotIndex = slotIndex + 4'h1;
		end else begin
			next_slotCount = slotCount + 9'h001;
			next_slotIndex = slotIndex;
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			slotCount <= 9'h000;
			slotIndex <= 4'h0;
		end else begin
			slotCount <= next_slotCount;
			slotIndex <= next_slotIndex;
		end
	end

	// Fixed frequency needs the enable and a high sink current
	assign currentHigh     = (sinkCurrent >= FIXED_MIN);
	assign fixedFreqWanted = freqSwitchOn && currentHigh;

	always @* begin
		next_sinkPwmOn   = 1'b1;
		next_pulseSkipOn = 1'b1;
		next_fixedFreqOn = 1'b0;
		case (modeSetting)
			// Shutdown: nothing to regulate, skipping allowed
			MODE_SHUT: begin
				next_sinkPwmOn   = 1'b1;
				next_pulseSkipOn = 1'b1;
				next_fixedFreqOn = 1'b0;
			end

			// Indicator: gated sink, skipping whatever the enable says
			MODE_IND: begin
				next_sinkPwmOn   = (slotIndex < dutySlots);
				next_pulseSkipOn = 1'b1;
				next_fixedFreqOn = 1'b0;
			end

			// Assist light: fixed frequency only when asked for
			MODE_ASST: begin
				next_sinkPwmOn   = 1'b1;
				next_pulseSkipOn = !fixedFreqWanted;
				next_fixedFreqOn = fixedFreqWanted;
			end

			// Flash: same policy as assist light
			MODE_FLSH: begin
				next_sinkPwmOn   = 1'b1;
				next_pulseSkipOn = !fixedFreqWanted;
				next_fixedFreqOn = fixedFreqWanted;
			end

			default: begin
				next_sinkPwmOn   = 1'b1;
				next_pulseSkipOn = 1'b1;
				next_fixedFreqOn = 1'b0;
			end
		endcase
	end

	// Every output leaves from a flip-flop
	always @(posedge clk_sys) begin
		if (reset)
			regRdData <= 8'h00;
		else
			regRdData <= next_regRdData;
	end

	always @(posedge clk_sys) begin
		if (reset)
			sinkPwmOn <= 1'b0;
		else
			sinkPwmOn <= next_sinkPwmOn;
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			pulseSkipOn <= 1'b1;
			fixedFreqOn <= 1'b0;
		end else begin
			pulseSkipOn <= next_pulseSkipOn;
			fixedFreqOn <= next_fixedFreqOn;
		end
	end
endmodule // ffp_fault_pwm_regs
`default_nettype wire

// ===== hw/ffp_sticky_flag.v
// One sticky fault flag, set by an event, cleared by a read.
// Assumes event and clear are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ffp_sticky_flag (
	input  wire clk_sys,
	input  wire reset,
	input  wire setEvent,
	input  wire clearFlag,
	output reg  flag
);
	always @(posedge clk_sys) begin
		if (reset)
			flag <= 1'b0;
		else if (setEvent)
			flag <= 1'b1;
		else if (clearFlag)
			flag <= 1'b0;
	end
endmodule // ffp_sticky_flag
`default_nettype wire

// ===== verification/ffp_fault_pwm_chk.sv
// Checker for the fault and pwm register pair.
// Bound to the register block; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ffp_fault_pwm_chk (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       regRead,
	input wire logic       uvloReduce,
	input wire logic       txmaskInput,
	input wire logic       flashActive,
	input wire logic       flashTimeout,
	input wire logic       overtempDetect,
	input wire logic       shortDetect,
	input wire logic       ovpDetect,
	input wire logic       pulseSkipOn,
	input wire logic       fixedFreqOn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regRdData,
	input wire logic [1:0] modeSetting
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire rf = regRead && regAddr == 8'h08;
	wire ev = uvloReduce | txmaskInput | flashTimeout | overtempDetect
		| shortDetect | ovpDetect;
	uvlo_kept_a: assert property (flashActive && uvloReduce ##1 rf
		|=> regRdData[0]) else $error("uvlo lost");
	mask_kept_a: assert property (flashActive && txmaskInput ##1 rf
		|=> regRdData[3]) else $error("mask lost");
	tout_kept_a: assert property (flashTimeout ##1 rf
		|=> regRdData[4]) else $error("timeout lost");
	temp_kept_a: assert property (overtempDetect ##1 rf
		|=> regRdData[5]) else $error("temp lost");
	short_kept_a: assert property (shortDetect ##1 rf
		|=> regRdData[6]) else $error("short lost");
	ovp_kept_a: assert property (ovpDetect ##1 rf |=> regRdData[7])
		else $error("ovp lost");
	read_clear_a: assert property (rf && !ev ##1 rf
		|=> regRdData == 8'h00) else $error("no clear");
	rsvd_zero_a: assert property (rf |=> regRdData[2:1] == 2'h0)
		else $error("reserved set");
	ind_skip_a: assert property ((modeSetting == 2'h1) [*3]
		|-> pulseSkipOn && !fixedFreqOn) else $error("indicator skip");
	cover property (rf ##1 rf);
	cover property (ovpDetect && rf);
	cover property (modeSetting == 2'h3 && !pulseSkipOn);
endmodule // ffp_fault_pwm_chk
bind ffp_fault_pwm_regs ffp_fault_pwm_chk ffp_fault_pwm_chk_inst (.*);
`default_nettype wire

// ===== verification/ffp_host_model.sv
// Host side model: byte register reads and writes.
// Assumes the block samples strobes on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ffp_host_model (
	input wire logic       clk_sys,
	input wire logic [7:0] regRdData,
	output var logic [7:0] regAddr = 0,
	output var logic [7:0] regWrData = 0,
	output var logic       regWrite = 0,
	output var logic       regRead = 0
);
	task acc(input logic w, input logic [7:0] a, d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrite <= w;
		regRead <= !w;
		@(posedge clk_sys);
		regWrite <= 0;
		regRead <= 0;
		regAddr <= ~a;
		regWrData <= ~d;
		#1;
	endtask
	// Two reads back to back; each result is taken while it stands
	task acc_pair(input logic [7:0] a, output logic [7:0] d1, d2);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1;
		@(posedge clk_sys);
		#1 d1 = regRdData;
		@(posedge clk_sys);
		regRead <= 0;
		regAddr <= ~a;
		#1 d2 = regRdData;
	endtask
endmodule // ffp_host_model
`default_nettype wire

// ===== verification/tb_ffp_fault_pwm_regs.sv
// Self-checking bench for the fault and pwm register pair.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_ffp_fault_pwm_regs;
	logic clk_sys = 0, reset = 1, flashActive = 0, regWrite, regRead;
	logic [7:0] regAddr, regWrData, regRdData, sinkCurrent = 0;
	logic sinkPwmOn, pulseSkipOn, fixedFreqOn;
	logic [1:0] modeSetting = 0;
	logic [7:0] d1, d2;
	logic [5:0] ev = 0;
	int error_cnt = 0, samples_checked = 0, cyc = 0, n;
	always #2 clk_sys = ~clk_sys;
	ffp_host_model host_inst (.clk_sys, .regAddr, .regWrData, .regWrite,
		.regRead, .regRdData);
	ffp_fault_pwm_regs ffp_fault_pwm_regs_inst (.clk_sys, .reset, .regAddr,
		.regWrData, .regWrite, .regRead, .regRdData, .modeSetting,
		.sinkCurrent, .flashActive, .uvloReduce(ev[0]), .txmaskInput(ev[1]),
		.flashTimeout(ev[2]), .overtempDetect(ev[3]), .shortDetect(ev[4]),
		.ovpDetect(ev[5]), .sinkPwmOn, .pulseSkipOn, .fixedFreqOn);
	task chk(input string s, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e)
			begin error_cnt++; $display("[FAIL] %s exp %h got %h", s, e, g); end
	endtask
	task rd(input logic [7:0] a, e);
		host_inst.acc(0, a, 0);
		chk("read", e, regRdData);
	endtask
	task pulse(input logic [5:0] v);
		@(posedge clk_sys) ev <= v;
		@(posedge clk_sys) ev <= 0;
	endtask
	task t_mode(input logic [1:0] m, input logic [7:0] c, input logic e);
		@(posedge clk_sys) modeSetting <= m;
		sinkCurrent <= c;
		repeat (3) @(posedge clk_sys);
		#1 chk("skip", e, pulseSkipOn);
		chk("fixed", !e, fixedFreqOn);
	endtask
	task close_out;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys) if (++cyc == 90000) begin
		error_cnt++;
		$display("[FAIL] cycle limit exp %0d got %0d", 89999, cyc);
		close_out();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		reset <= 0;
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h33, 8'h00);
		pulse(6'h03);
		rd(8'h08, 8'h00);
		@(posedge clk_sys) flashActive <= 1;
		for (int i = 0; i < 6; i++) begin
			fork
				pulse(6'h01 << i);
				begin
					@(posedge clk_sys);
					host_inst.acc(0, 8'h08, 0);
				end
			join
			chk("flag", i ? 8'h04 << i : 8'h01, regRdData);
			rd(8'h08, 8'h00);
		end
		pulse(6'h10);
		host_inst.acc_pair(8'h08, d1, d2);
		chk("pair first", 8'h40, d1);
		chk("pair second", 8'h00, d2);
		fork
			host_inst.acc(0, 8'h08, 0);
			pulse(6'h20);
		join
		chk("race", 8'h00, regRdData);
		rd(8'h08, 8'h80);
		host_inst.acc(1, 8'h08, 8'hff);
		host_inst.acc(1, 8'h09, 8'hff);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h07);
		t_mode(2'h3, 8'h40, 0);
		t_mode(2'h2, 8'h40, 0);
		t_mode(2'h3, 8'h3f, 1);
		t_mode(2'h0, 8'hff, 1);
		t_mode(2'h1, 8'h40, 1);
		host_inst.acc(1, 8'h09, 8'h00);
		t_mode(2'h3, 8'h40, 1);
		t_mode(2'h1, 8'hff, 1);
		for (int c = 0; c < 4; c++) begin
			host_inst.acc(1, 8'h09, c[7:0]);
			repeat (8000) @(posedge clk_sys);
			n = 0;
			repeat (8000) @(negedge clk_sys) n += sinkPwmOn;
			chk("duty", (c + 1) * 500, n[15:0]);
		end
		close_out();
	end
endmodule // tb_ffp_fault_pwm_regs
`default_nettype wire
